// ==== dv/sss_plc_model.sv ====
module sss_plc_model (
	// Clock
	input wire logic sys_clk,
	// Control
	input wire logic edge_mode,
	input wire logic close_req,
	// Feedback circuit
	output logic     feedback_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// =====================================
	// Feedback circuit, open reads low
	int unsigned hold_q;
	always_ff @(posedge sys_clk) begin
		if (!close_req)
			hold_q <= 0;
		else if (hold_q < 9)
			hold_q <= hold_q + 1;
	end
	// Edge variant opens after a short pulse so a fall is seen
	assign feedback_in = close_req &&
		(!edge_mode || (hold_q > 0 && hold_q < 9));
endmodule : sss_plc_model

// ==== dv/sss_status_properties.sv ====
module sss_status_checker #(
	parameter longint unsigned WARN_CYCLES = 64'h32
) (
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       reset,
	// Inputs
	input wire logic       safety_input_a,
	input wire logic       actuator_present,
	input wire logic [5:0] error_cause,
	input wire logic       internal_fault,
	input wire logic       warning_cause,
	input wire logic       teach_active,
	input wire logic       teach_done,
	// Outputs
	input wire logic       led_red,
	input wire logic       diag_out,
	input wire logic       safety_output_a,
	input wire logic       safety_output_b,
	input wire logic [2:0] error_code
);
	timeunit 1ns;
	timeprecision 1ps;
	// =====================================
	// Warning age, the trip is too long for a repetition
	longint unsigned wcnt_q;
	always_ff @(posedge sys_clk) begin
		if (reset || !warning_cause)
			wcnt_q <= 64'h0;
		else
			wcnt_q <= wcnt_q + 64'h1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// =====================================
	// Properties
	leave_drops_a: assert property (!actuator_present |=>
		!safety_output_a && !safety_output_b) else $error("outputs kept");
	fault_off_a: assert property (internal_fault |=> ##[0:1]
		!safety_output_a) else $error("fault left outputs on");
	code_latch_a: assert property (error_cause == 6'h08 ##1
		error_code == 3'h0 |=> error_code == 3'h4)
		else $error("code not latched");
	input_off_a: assert property ((!safety_input_a)[*6] |->
		!safety_output_a && !safety_output_b) else $error("outputs on");
	teach_show_a: assert property (teach_active[*3] |-> led_red &&
		!diag_out && !safety_output_a) else $error("teach display wrong");
	fault_red_a: assert property (internal_fault[*3] |-> led_red)
		else $error("red not on");
	warn_diag_a: assert property ((warning_cause && error_code == 3'h0 &&
		!internal_fault && !teach_active)[*3] |-> !diag_out)
		else $error("diag high in warning");
	warn_trip_a: assert property (wcnt_q > WARN_CYCLES + 64'h2 |->
		!safety_output_a) else $error("no trip");
	inhibit_off_a: assert property (teach_done |=> ##1
		(!safety_output_a && !diag_out)[*8]) else $error("inhibit broken");
	rel_c: cover property ($rose(safety_output_a));
	err_c: cover property (error_code == 3'h6);
	trip_c: cover property (wcnt_q > WARN_CYCLES + 64'h2);
endmodule : sss_status_checker

bind sss_status sss_status_checker #(.WARN_CYCLES(WARN_CYCLES)) u_chk (.*);

// ==== dv/sss_status_tb.sv ====
module sss_status_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// =====================================
	// Signals
	logic       sys_clk, reset, safety_input_a, safety_input_b;
	logic       feedback_in, actuator_present, actuator_limit;
	logic       internal_fault, warning_cause, teach_active, teach_done;
	logic       inhibit_resume, feedback_edge_variant, close_req;
	logic       led_green, led_red, led_yellow, diag_out;
	logic       safety_output_a, safety_output_b;
	logic [5:0] error_cause;
	logic [2:0] error_code;
	int         error_cnt, n_checks, cyc;
	sss_pkg::sss_ind_s ind;
	assign ind = '{led_green, led_red, led_yellow, diag_out, safety_output_a};

	sss_status #(
		.TICK_CYCLES   (4),
		.WARN_CYCLES   (64'h32),
		.INHIBIT_CYCLES(64'h28)
	) dut (.*);
	sss_plc_model u_plc (.sys_clk, .edge_mode(feedback_edge_variant),
		.close_req, .feedback_in);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// =====================================
	// Shared tasks
	task automatic complete_run();
		if (error_cnt == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step
	// Flashing shows as seen-high set but all-high clear
	task automatic look(input int n, input logic [4:0] e_any, e_all);
		logic [4:0] any, all;
		any = 5'h00;
		all = 5'h1F;
		step(8);
		repeat (n) begin
			step(1);
			any = any | ind;
			all = all & ind;
		end
		chk({3'h0, any}, {3'h0, e_any});
		chk({3'h0, all}, {3'h0, e_all});
	endtask : look
	task automatic wait_safe(input logic exp);
		int k;
		k = 0;
		while (safety_output_a !== exp && k < 300) begin
			step(1);
			k++;
		end
		chk({7'h0, safety_output_a}, {7'h0, exp});
		chk({7'h0, safety_output_b}, {7'h0, exp});
	endtask : wait_safe
	task automatic guard();
		actuator_present = 1'b0;
		step(2);
		actuator_present = 1'b1;
		step(2);
	endtask : guard
	// Counts one red group; a dark run of 12 cycles marks the pause
	task automatic count_red(output int n);
		int   lo;
		logic was;
		lo = 0;
		n = 0;
		while (lo < 12) begin
			step(1);
			lo = led_red ? 0 : lo + 1;
		end
		while (led_red !== 1'b1)
			step(1);
		was = 1'b1;
		n = 1;
		lo = 0;
		while (lo < 12) begin
			step(1);
			if (led_red && !was)
				n++;
			was = led_red;
			lo = led_red ? 0 : lo + 1;
		end
	endtask : count_red
	// =====================================
	// Scenarios
	task automatic t_basic();
		look(48, 5'h10, 5'h10);
		actuator_present = 1'b1;
		wait_safe(1'b1);
		look(48, 5'h07, 5'h07);
		actuator_present = 1'b0;
		step(1);
		chk({7'h0, safety_output_a}, 8'h00);
		actuator_present = 1'b1;
		actuator_limit = 1'b1;
		look(48, 5'h07, 5'h01);
		actuator_limit = 1'b0;
	endtask : t_basic
	task automatic t_inputs();
		safety_input_a = 1'b0;
		look(48, 5'h16, 5'h06);
		{safety_input_a, safety_input_b, actuator_present} = 3'h4;
		look(48, 5'h10, 5'h00);
		safety_input_b = 1'b1;
		actuator_present = 1'b1;
		wait_safe(1'b1);
	endtask : t_inputs
	task automatic t_errors();
		int np;
		for (int i = 0; i < 6; i++) begin
			error_cause = 6'h01 << i;
			step(1);
			error_cause = 6'h01 << ((i + 1) % 6);
			step(1);
			error_cause = 6'h00;
			count_red(np);
			chk(8'(np), 8'(i + 1));
			look(48, 5'h08, 5'h00);
			chk({5'h0, error_code}, 8'(i + 1));
			guard();
			step(2);
			chk({5'h0, error_code}, 8'h00);
			wait_safe(1'b1);
		end
		internal_fault = 1'b1;
		look(24, 5'h08, 5'h08);
		internal_fault = 1'b0;
		guard();
		wait_safe(1'b1);
	endtask : t_errors
	task automatic t_warn();
		warning_cause = 1'b1;
		look(30, 5'h09, 5'h01);
		step(20);
		look(30, 5'h08, 5'h00);
		warning_cause = 1'b0;
		wait_safe(1'b1);
	endtask : t_warn
	task automatic t_teach();
		teach_active = 1'b1;
		look(48, 5'h0C, 5'h08);
		teach_done = 1'b1;
		step(1);
		teach_done = 1'b0;
		teach_active = 1'b0;
		look(24, 5'h10, 5'h00);
		wait_safe(1'b1);
	endtask : t_teach
	// Power returns with an inhibit still pending
	task automatic t_power();
		inhibit_resume = 1'b1;
		reset = 1'b1;
		step(20);
		reset = 1'b0;
		look(24, 5'h10, 5'h00);
		inhibit_resume = 1'b0;
		wait_safe(1'b1);
	endtask : t_power
	task automatic t_feedback(input logic variant);
		feedback_edge_variant = variant;
		close_req = 1'b0;
		step(6);
		guard();
		look(16, 5'h16, 5'h12);
		close_req = 1'b1;
		wait_safe(1'b1);
	endtask : t_feedback
	// =====================================
	// Main sequence and hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			complete_run();
		end
	end
	initial begin
		{safety_input_a, safety_input_b, actuator_present} = 3'h0;
		{actuator_limit, internal_fault, warning_cause} = 3'h0;
		{teach_active, teach_done, inhibit_resume} = 3'h0;
		{feedback_edge_variant, close_req} = 2'h0;
		error_cause = 6'h00;
		reset = 1'b1;
		step(20);
		reset = 1'b0;
		{safety_input_a, safety_input_b, close_req} = 3'h7;
		t_basic();
		t_inputs();
		t_errors();
		t_warn();
		t_teach();
		t_power();
		t_feedback(1'b0);
		t_feedback(1'b1);
		complete_run();
	end
endmodule : sss_status_tb

// ==== pkg/sss_params.svh ====
// Notes on behaviour
// - Green steady when ready, both inputs live
// - Green flashes 1 Hz on missing input
// - Yellow lit while actuator in range
// - Yellow flashes in marginal limit area
// - Red lit on any error
// - Red pulse groups encode error cause
// - Teaching: red on, yellow flashes, outputs off
// - Internal fault holds red on
// - Diagnostic output mirrors switching condition
// - Limit area pulses diagnostic, outputs stay on
// - Internal error disables both safety outputs
// - Latched error clears after guard open-close
// - Warning: diagnostic low, safety outputs on
// - Warning clears itself when cause gone
// - Warning for 30 minutes trips outputs off
// - Await feedback circuit, diagnostic high
// - Actuator but input missing: green flash
// - No actuator, input missing: green only
// - Actuator leaving zone drops outputs at once
// - Ten-minute inhibit after teach, survives power
`ifndef SSS_PARAMS_SVH
`define SSS_PARAMS_SVH

// =====================================================
// Timing
`define SSS_CLK_HZ       100000000
`define SSS_TICK_MS      100
`define SSS_WARN_MIN     30
`define SSS_INHIBIT_MIN  10
`define SSS_SLOW_DIV     5
`define SSS_PULSE_TICKS  2
`define SSS_PAUSE_TICKS  10

// =====================================================
// Pin synchroniser
`define SSS_SYNC_PINS    3
`define SSS_PIN_IN_A     0
`define SSS_PIN_IN_B     1
`define SSS_PIN_FB       2

`endif

// ==== pkg/sss_pkg.sv ====
package sss_pkg;

	// =====================================================
	// Flash timebase
	typedef struct packed {
		logic tick;
		logic slow;
		logic fast;
	} sss_flash_s;

	// =====================================================
	// Latched error cause, value is the red pulse count
	typedef enum logic [2:0] {
		SSS_ERR_NONE  = 3'h0,
		SSS_ERR_OUT_A = 3'h1,
		SSS_ERR_OUT_B = 3'h2,
		SSS_ERR_CROSS = 3'h3,
		SSS_ERR_TEMP  = 3'h4,
		SSS_ERR_ACT   = 3'h5,
		SSS_ERR_DISC  = 3'h6
	} sss_err_e;

	// =====================================================
	// Indicator and output bundle
	typedef struct packed {
		logic green;
		logic red;
		logic yellow;
		logic diag;
		logic safe;
	} sss_ind_s;

endpackage : sss_pkg

// ==== rtl/sss_flash.sv ====
`include "sss_params.svh"

module sss_flash #(
	parameter int unsigned TICK_CYCLES = 32'd10000000
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              reset,
	// Timebase
	output sss_pkg::sss_flash_s    flash
);

	// =====================================================
	// Prescaler
	logic [31:0] pre_q;
	logic [2:0]  slow_q;
	logic        fast_q;
	logic        slow_ph_q;
	logic        tick_q;

	wire pre_end  = (pre_q == TICK_CYCLES - 32'd1);
	wire slow_end = (slow_q == 3'(`SSS_SLOW_DIV - 1));

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pre_q     <= 32'h0;
			slow_q    <= 3'h0;
			fast_q    <= 1'b0;
			slow_ph_q <= 1'b0;
			tick_q    <= 1'b0;
		end else begin
			pre_q  <= pre_end ? 32'h0 : pre_q + 32'd1;
			tick_q <= pre_end;
			if (pre_end) begin
				fast_q <= ~fast_q;
				slow_q <= slow_end ? 3'h0 : slow_q + 3'h1;
				if (slow_end)
					slow_ph_q <= ~slow_ph_q;
			end
		end
	end

	assign flash.tick = tick_q;
	assign flash.slow = slow_ph_q;
	assign flash.fast = fast_q;

endmodule : sss_flash

// ==== rtl/sss_status.sv ====
`include "sss_params.svh"

module sss_status #(
	parameter int unsigned      TICK_CYCLES =
		32'(`SSS_TICK_MS * (`SSS_CLK_HZ / 1000)),
	parameter longint unsigned  WARN_CYCLES =
		64'(`SSS_WARN_MIN) * 64'd60 * 64'(`SSS_CLK_HZ),
	parameter longint unsigned  INHIBIT_CYCLES =
		64'(`SSS_INHIBIT_MIN) * 64'd60 * 64'(`SSS_CLK_HZ)
) (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset,
	// Pins from the field
	input  wire logic       safety_input_a,
	input  wire logic       safety_input_b,
	input  wire logic       feedback_in,
	// Sensing front end and monitors
	input  wire logic       actuator_present,
	input  wire logic       actuator_limit,
	input  wire logic [5:0] error_cause,
	input  wire logic       internal_fault,
	input  wire logic       warning_cause,
	// Teach and configuration
	input  wire logic       teach_active,
	input  wire logic       teach_done,
	input  wire logic       inhibit_resume,
	input  wire logic       feedback_edge_variant,
	// Indicators
	output logic            led_green,
	output logic            led_red,
	output logic            led_yellow,
	// Outputs
	output logic            diag_out,
	output logic            safety_output_a,
	output logic            safety_output_b,
	output logic [2:0]      error_code
);

	localparam int WW = $clog2(WARN_CYCLES + 64'd1);
	localparam int IW = $clog2(INHIBIT_CYCLES + 64'd1);

	// =====================================================
	// Flash timebase
	sss_pkg::sss_flash_s flash;

	sss_flash #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_flash (
		.sys_clk (sys_clk),
		.reset   (reset),
		.flash   (flash)
	);

	// =====================================================
	// Pin synchronisers; a change counts once stages 2 and 3 agree
	logic [`SSS_SYNC_PINS-1:0] pin_raw;
	logic [`SSS_SYNC_PINS-1:0] pin_f;

	assign pin_raw[`SSS_PIN_IN_A] = safety_input_a;
	assign pin_raw[`SSS_PIN_IN_B] = safety_input_b;
	assign pin_raw[`SSS_PIN_FB]   = feedback_in;

	genvar gi;
	generate
		for (gi = 0; gi < `SSS_SYNC_PINS; gi++) begin : g_sync
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic f_q;
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					f_q  <= 1'b0;
				end else begin
					s1_q <= pin_raw[gi];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q)
						f_q <= s3_q;
				end
			end
			assign pin_f[gi] = f_q;
		end
	endgenerate

	wire inputs_ok = pin_f[`SSS_PIN_IN_A] & pin_f[`SSS_PIN_IN_B];
	wire fb_lvl    = pin_f[`SSS_PIN_FB];

	// =====================================================
	// Error latch, first cause wins
	sss_pkg::sss_err_e err_q;
	sss_pkg::sss_err_e err_new;
	logic              fault_q;
	logic              opened_q;
	logic              fb_prev_q;

	always_comb begin
		err_new = sss_pkg::SSS_ERR_NONE;
		for (int i = 5; i >= 0; i--)
			if (error_cause[i])
				err_new = sss_pkg::sss_err_e'(3'(i + 1));
	end

	wire latched     = (err_q != sss_pkg::SSS_ERR_NONE) | fault_q;
	wire cause_gone  = (error_cause == 6'h00) & ~internal_fault;
	// Guard must open then close again before the latch lets go
	wire guard_clear = latched & opened_q & actuator_present
		& cause_gone;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			err_q    <= sss_pkg::SSS_ERR_NONE;
			fault_q  <= 1'b0;
			opened_q <= 1'b0;
		end else begin
			if (guard_clear) begin
				err_q    <= sss_pkg::SSS_ERR_NONE;
				fault_q  <= 1'b0;
				opened_q <= 1'b0;
			end else begin
				if (err_q == sss_pkg::SSS_ERR_NONE)
					err_q <= err_new;
				if (internal_fault)
					fault_q <= 1'b1;
				if (latched & ~actuator_present)
					opened_q <= 1'b1;
			end
		end
	end

	// =====================================================
	// Warning timer; clears itself when the cause goes
	logic [WW-1:0] warn_cnt_q;
	logic          trip_q;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			warn_cnt_q <= '0;
			trip_q     <= 1'b0;
		end else if (~warning_cause) begin
			warn_cnt_q <= '0;
			trip_q     <= 1'b0;
		end else if (warn_cnt_q == WW'(WARN_CYCLES - 64'd1)) begin
			trip_q <= 1'b1;
		end else begin
			warn_cnt_q <= warn_cnt_q + WW'(1);
		end
	end

	wire warn = warning_cause & ~trip_q;

	// =====================================================
	// Enabling inhibit after teach; a pending period is
	// resumed from scratch after power returns
	logic [IW-1:0] inh_cnt_q;
	logic          inhibit_q;
	logic          boot_q;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			inh_cnt_q <= '0;
			inhibit_q <= 1'b0;
			boot_q    <= 1'b1;
		end else begin
			boot_q <= 1'b0;
			if (teach_done | (boot_q & inhibit_resume)) begin
				inhibit_q <= 1'b1;
				inh_cnt_q <= '0;
			end else if (inhibit_q) begin
				if (inh_cnt_q == IW'(INHIBIT_CYCLES - 64'd1))
					inhibit_q <= 1'b0;
				else
					inh_cnt_q <= inh_cnt_q + IW'(1);
			end
		end
	end

	// =====================================================
	// Release through the feedback circuit
	logic released_q;

	wire blocked = latched | trip_q | teach_active | inhibit_q;
	// Any loss of actuator drops release the very next edge
	wire enable_ok = actuator_present & inputs_ok & ~blocked;
	wire fb_fall   = fb_prev_q & ~fb_lvl;
	wire fb_go     = feedback_edge_variant ? fb_fall : fb_lvl;
	wire waiting   = enable_ok & ~released_q;
	wire safe_d    = enable_ok & released_q;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			released_q <= 1'b0;
			fb_prev_q  <= 1'b0;
		end else begin
			fb_prev_q <= fb_lvl;
			if (~enable_ok)
				released_q <= 1'b0;
			else if (fb_go)
				released_q <= 1'b1;
		end
	end

	// =====================================================
	// Red pulse code sequencer, counted in ticks
	// Six bits: the longest group with its pause is 34 ticks
	logic [5:0] pc_q;

	wire [5:0] code_len = 6'(2 * `SSS_PULSE_TICKS * err_q);
	wire [5:0] grp_len  = code_len + 6'(`SSS_PAUSE_TICKS);
	wire       pulse_on = (pc_q < code_len)
		& (pc_q[1] == 1'b0);

	always_ff @(posedge sys_clk) begin
		if (reset)
			pc_q <= 6'h00;
		else if (err_q == sss_pkg::SSS_ERR_NONE)
			pc_q <= 6'h00;
		else if (flash.tick)
			pc_q <= (pc_q >= grp_len - 6'h01) ? 6'h00 : pc_q + 6'h01;
	end

	// =====================================================
	// Indicator decode
	logic green_d;
	logic red_d;
	logic yellow_d;
	logic diag_d;

	wire err_act = err_q != sss_pkg::SSS_ERR_NONE;
	wire alt_fl  = flash.slow ? flash.fast : 1'b1;

	always_comb begin
		if (inhibit_q | ~inputs_ok)
			green_d = flash.slow;
		else if (blocked | warn | actuator_present)
			green_d = waiting;
		else
			green_d = 1'b1;
	end

	always_comb begin
		if (fault_q | teach_active)
			red_d = 1'b1;
		else if (err_act)
			red_d = pulse_on;
		else if (trip_q | warn)
			red_d = flash.slow;
		else
			red_d = 1'b0;
	end

	always_comb begin
		if (teach_active)
			yellow_d = flash.slow;
		else if (latched | warn | trip_q | inhibit_q)
			yellow_d = 1'b0;
		else if (~actuator_present)
			yellow_d = 1'b0;
		else if (actuator_limit)
			yellow_d = waiting ? alt_fl : flash.slow;
		else if (waiting)
			yellow_d = flash.fast;
		else
			yellow_d = 1'b1;
	end

	always_comb begin
		if (blocked | warn | trip_q)
			diag_d = 1'b0;
		else if (~actuator_present)
			diag_d = 1'b0;
		else if (actuator_limit)
			diag_d = flash.fast;
		else
			diag_d = 1'b1;
	end

	// =====================================================
	// Output registers
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			led_green       <= 1'b0;
			led_red         <= 1'b0;
			led_yellow      <= 1'b0;
			diag_out        <= 1'b0;
			safety_output_a <= 1'b0;
			safety_output_b <= 1'b0;
			error_code      <= 3'h0;
		end else begin
			led_green       <= green_d;
			led_red         <= red_d;
			led_yellow      <= yellow_d;
			diag_out        <= diag_d;
			safety_output_a <= safe_d;
			safety_output_b <= safe_d;
			error_code      <= err_q;
		end
	end

endmodule : sss_status
